// file: hdl/ipt_pkg.sv
/*
 * constants for the interrupt priority and trap control block: register
 * offsets, field positions, reset values and widths.
 * assumes a 16-bit register port with byte addresses on even boundaries.
 */
package ipt_pkg;
  localparam int NUM_SRC = 16;
  localparam int DW = 16;
  localparam int AW = 8;
  // ==========================================================================
  // register offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CORE = 8'h02;
  localparam logic [7:0] OFS_TRAP1 = 8'h04;
  localparam logic [7:0] OFS_TRAP2 = 8'h06;
  localparam logic [7:0] OFS_TRAP3 = 8'h08;
  localparam logic [7:0] OFS_TRAP4 = 8'h0a;
  localparam logic [7:0] OFS_PEND = 8'h0c;
  localparam logic [7:0] OFS_FLAG = 8'h10;
  localparam logic [7:0] OFS_ENABLE = 8'h12;
  localparam logic [7:0] OFS_PRIO0 = 8'h14;
  localparam logic [7:0] OFS_PRIO3 = 8'h1a;
  // ==========================================================================
  // field positions
  localparam int IPL_LSB = 5;
  localparam int IPL_MSB = 7;
  localparam int CORE_VAR = 15;
  localparam int CORE_CPU_PRIORITY_MSB = 3;
  localparam int T1_NEST = 15;
  localparam int T1_ACC_A_OVF = 14;
  localparam int T1_ACC_B_OVF = 13;
  localparam int T1_ACC_A_CAT = 12;
  localparam int T1_ACC_B_CAT = 11;
  localparam int T1_A_TE = 10;
  localparam int T1_B_TE = 9;
  localparam int T1_CAT_TE = 8;
  localparam int T1_SHIFT = 7;
  localparam int T1_DIV0 = 6;
  localparam int T1_DMA = 5;
  localparam int T1_MATH = 4;
  localparam int T1_ADDR = 3;
  localparam int T1_STACK = 2;
  localparam int T1_OSC = 1;
  localparam int T2_GIE = 15;
  localparam int T3_DMA_ADDR = 5;
  localparam int T3_LOOP_OVF = 4;
  localparam int T4_SOFT_HARD = 0;
  localparam int PEND_LVL_LSB = 8;
  localparam int NUM_EXT = 3;
  localparam int PRIO_W = 3;
  localparam int PRIO_STRIDE = 4;
  localparam int SRC_PER_PRIO = 4;
  // ==========================================================================
  // masks and reset values
  localparam logic [15:0] T1_WR_MASK = 16'hfffe;
  localparam logic [15:0] T1_FLAG_MASK = 16'h78fe;
  localparam logic [15:0] T2_WR_MASK = 16'h8007;
  localparam logic [15:0] T2_RESET = 16'h8000;
  localparam logic [15:0] T3_WR_MASK = 16'h0030;
  localparam logic [15:0] T4_WR_MASK = 16'h0001;
  localparam logic [2:0] LVL_LOW_MAX = 3'h7;
  // trap event input positions
  localparam int EV_ACC_A_OVF = 0;
  localparam int EV_ACC_B_OVF = 1;
  localparam int EV_ACC_A_CAT = 2;
  localparam int EV_ACC_B_CAT = 3;
  localparam int EV_SHIFT = 4;
  localparam int EV_DIV0 = 5;
  localparam int EV_DMA = 6;
  localparam int EV_MATH = 7;
  localparam int EV_ADDR = 8;
  localparam int EV_STACK = 9;
  localparam int EV_OSC = 10;
  localparam int EV_DMA_ADDR = 11;
  localparam int EV_LOOP_OVF = 12;
  localparam int EV_SOFT_HARD = 13;
  localparam int NUM_EV = 14;
endpackage : ipt_pkg

// file: hdl/ipt_edge_if.sv
/*
 * carrier between the controller and one external request edge detector.
 * assumes both ends run on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
interface ipt_edge_if;
  logic falling_sel;
  logic edge_seen;
  modport det (input falling_sel, output edge_seen);
  modport ctl (output falling_sel, input edge_seen);
endinterface : ipt_edge_if
`default_nettype wire

// file: hdl/ipt_edge_detect.sv
/*
 * one external request pin: two-stage synchroniser and edge detector with
 * polarity select; emits a one-cycle pulse per chosen edge.
 * assumes the pin is asynchronous to ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module ipt_edge_detect
  import ipt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic pin_raw,
  ipt_edge_if.det eif
);
  logic meta_q;
  logic sync_q;
  logic prev_q;
  logic pulse_q;
  // first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= eif.falling_sel ? (prev_q & ~sync_q) : (~prev_q & sync_q);
    end
  end
  assign eif.edge_seen = pulse_q;
endmodule : ipt_edge_detect
`default_nettype wire

// file: hdl/ipt_ctrl.sv
/*
 * interrupt priority and trap control: request flags, enables, priorities,
 * cpu priority level, pending vector latch, trap cause flags and control.
 * assumes peripheral requests and trap events are one-cycle pulses on
 * ref_clk, and the core acknowledges with one-cycle pulses.
 */
// Design decisions made here: the register offsets and the address-and-strobe port.
// Behaviour
// - hardware sets request flag, software write clears
// - one enable bit per source
// - three-bit priority per source, eight levels
// - latch pending vector and its level
// - bit positions follow vector order
// - status bits 7:5 hold writable low level
// - level high bit read-only to software
// - level is high bit joined above low bits
// - user interrupts blocked at high bit or 111
// - nesting disable makes low level read-only
// - nesting disable bit resets to zero
// - high bit reads one above level 7
// - core bit 15 selects variable latency
// - accumulator overflow and catastrophic trap flags
// - accumulator overflow trap enable bits
// - bad shift and divide zero flags
// - dma trap and math trap flags
// - control two: global enable, pin polarity
// - control three and four trap flags
// - global enable clear blocks interrupts, not traps
// - vector code zero means vector 8
// - polarity one falling edge, zero rising
`timescale 1ns/1ps
`default_nettype none
module ipt_ctrl
  import ipt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [AW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DW-1:0] reg_rdata,
  input wire logic [NUM_EXT-1:0] ext_pin,
  input wire logic [NUM_SRC-1:0] periph_req,
  input wire logic [NUM_EV-1:0] trap_evt,
  input wire logic irq_ack,
  input wire logic level_load,
  input wire logic [3:0] level_value,
  output logic irq_req,
  output logic [6:0] irq_vector,
  output logic [3:0] irq_level,
  output logic trap_req,
  output logic [3:0] cpu_level,
  output logic var_latency
);
  // ==========================================================================
  // state
  logic [NUM_SRC-1:0] flag_q;
  logic [NUM_SRC-1:0] enable_q;
  logic [PRIO_W-1:0] prio_q [NUM_SRC];
  logic [2:0] lvl_low_q;
  logic lvl_msb_q;
  logic var_q;
  logic [DW-1:0] t1_q;
  logic [DW-1:0] t2_q;
  logic [DW-1:0] t3_q;
  logic [DW-1:0] t4_q;
  logic [6:0] pend_vec_q;
  logic [3:0] pend_lvl_q;
  logic req_q;
  logic trap_q;
  logic [DW-1:0] rdata_q;
  logic [NUM_SRC-1:0] hw_set;
  logic [NUM_EXT-1:0] ext_edge;
  logic [3:0] cur_lvl;
  logic nest_dis;
  logic global_irq_enable;
  assign cur_lvl = {lvl_msb_q, lvl_low_q};
  assign nest_dis = t1_q[T1_NEST];
  assign global_irq_enable = t2_q[T2_GIE];
  // ==========================================================================
  // external request pins
  // a pin idling high on rising polarity shows one edge after reset
  ipt_edge_if eif [NUM_EXT] ();
  genvar g;
  generate
    for (g = 0; g < NUM_EXT; g++) begin : g_ext
      assign eif[g].falling_sel = t2_q[g];
      assign ext_edge[g] = eif[g].edge_seen;
      ipt_edge_detect u_edge (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .pin_raw(ext_pin[g]),
        .eif(eif[g])
      );
    end
  endgenerate
  // external pins take the lowest natural order positions
  always_comb begin
    hw_set = periph_req;
    hw_set[NUM_EXT-1:0] = periph_req[NUM_EXT-1:0] | ext_edge;
  end
  // ==========================================================================
  // request flags and enables
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      flag_q <= '0;
    end else if (reg_wr && reg_addr == OFS_FLAG) begin
      flag_q <= (flag_q & reg_wdata) | hw_set; // set wins over clear
    end else begin
      flag_q <= flag_q | hw_set;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      enable_q <= '0;
    end else if (reg_wr && reg_addr == OFS_ENABLE) begin
      enable_q <= reg_wdata;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_SRC; i++) prio_q[i] <= '0;
    end else if (reg_wr && reg_addr >= OFS_PRIO0 && reg_addr <= OFS_PRIO3 && !reg_addr[0]) begin
      for (int j = 0; j < SRC_PER_PRIO; j++) begin
        prio_q[(32'(reg_addr - OFS_PRIO0) >> 1) * SRC_PER_PRIO + j] <=
          reg_wdata[j*PRIO_STRIDE +: PRIO_W];
      end
    end
  end
  // ==========================================================================
  // cpu priority level; the core path wins over a software write
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lvl_low_q <= '0;
      lvl_msb_q <= 1'b0;
    end else if (level_load) begin
      lvl_low_q <= level_value[2:0];
      lvl_msb_q <= level_value[3]; // only the core moves it
    end else if (irq_ack && req_q) begin
      // with nesting off the handler runs at 7 so no user interrupt preempts it
      lvl_low_q <= nest_dis ? LVL_LOW_MAX : pend_lvl_q[2:0];
    end else if (reg_wr && reg_addr == OFS_STATUS && !nest_dis) begin
      lvl_low_q <= reg_wdata[IPL_MSB:IPL_LSB];
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      var_q <= 1'b0;
    end else if (reg_wr && reg_addr == OFS_CORE) begin
      var_q <= reg_wdata[CORE_VAR];
    end
  end
  // ==========================================================================
  // trap control and status registers
  logic [DW-1:0] t1_set;
  always_comb begin
    t1_set = '0;
    t1_set[T1_ACC_A_OVF] = trap_evt[EV_ACC_A_OVF] & t1_q[T1_A_TE];
    t1_set[T1_ACC_B_OVF] = trap_evt[EV_ACC_B_OVF] & t1_q[T1_B_TE];
    t1_set[T1_ACC_A_CAT] = trap_evt[EV_ACC_A_CAT] & t1_q[T1_CAT_TE];
    t1_set[T1_ACC_B_CAT] = trap_evt[EV_ACC_B_CAT] & t1_q[T1_CAT_TE];
    t1_set[T1_SHIFT] = trap_evt[EV_SHIFT];
    t1_set[T1_DIV0] = trap_evt[EV_DIV0];
    t1_set[T1_DMA] = trap_evt[EV_DMA];
    t1_set[T1_MATH] = trap_evt[EV_MATH] | trap_evt[EV_SHIFT] | trap_evt[EV_DIV0];
    t1_set[T1_ADDR] = trap_evt[EV_ADDR];
    t1_set[T1_STACK] = trap_evt[EV_STACK];
    t1_set[T1_OSC] = trap_evt[EV_OSC];
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      t1_q <= '0;
    end else if (reg_wr && reg_addr == OFS_TRAP1) begin
      t1_q <= (reg_wdata & T1_WR_MASK) | t1_set;
    end else begin
      t1_q <= t1_q | t1_set;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      t2_q <= T2_RESET;
    end else if (reg_wr && reg_addr == OFS_TRAP2) begin
      t2_q <= reg_wdata & T2_WR_MASK;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      t3_q <= '0;
      t4_q <= '0;
    end else begin
      t3_q[T3_DMA_ADDR] <= trap_evt[EV_DMA_ADDR] |
        ((reg_wr && reg_addr == OFS_TRAP3) ? reg_wdata[T3_DMA_ADDR] : t3_q[T3_DMA_ADDR]);
      t3_q[T3_LOOP_OVF] <= trap_evt[EV_LOOP_OVF] |
        ((reg_wr && reg_addr == OFS_TRAP3) ? reg_wdata[T3_LOOP_OVF] : t3_q[T3_LOOP_OVF]);
      t4_q[T4_SOFT_HARD] <= trap_evt[EV_SOFT_HARD] |
        ((reg_wr && reg_addr == OFS_TRAP4) ? reg_wdata[T4_SOFT_HARD] : t4_q[T4_SOFT_HARD]);
    end
  end
  // traps ignore the global enable and the cpu level
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      trap_q <= 1'b0;
    end else begin
      trap_q <= |(t1_q & T1_FLAG_MASK) | |(t3_q & T3_WR_MASK) | |(t4_q & T4_WR_MASK);
    end
  end
  // ==========================================================================
  // arbitration: ascending scan with strict compare keeps the lower vector
  logic [NUM_SRC-1:0] eligible;
  logic [6:0] best_idx;
  logic [3:0] best_lvl;
  logic any_elig;
  always_comb begin
    best_idx = '0;
    best_lvl = '0;
    any_elig = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      // a zero-extended priority never exceeds 8..15 nor level 7
      eligible[i] = flag_q[i] & enable_q[i] & global_irq_enable & ({1'b0, prio_q[i]} > cur_lvl);
      if (eligible[i] && (!any_elig || {1'b0, prio_q[i]} > best_lvl)) begin
        best_idx = 7'(i);
        best_lvl = {1'b0, prio_q[i]};
        any_elig = 1'b1;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pend_vec_q <= '0;
      pend_lvl_q <= '0;
      req_q <= 1'b0;
    end else begin
      req_q <= any_elig;
      if (any_elig) begin
        pend_vec_q <= best_idx;
        pend_lvl_q <= best_lvl;
      end
    end
  end
  // ==========================================================================
  // register read port; unmapped offsets read zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      rdata_q <= '0;
      case (reg_addr)
        OFS_STATUS: rdata_q[IPL_MSB:IPL_LSB] <= lvl_low_q;
        OFS_CORE: begin
          rdata_q[CORE_VAR] <= var_q;
          rdata_q[CORE_CPU_PRIORITY_MSB] <= lvl_msb_q;
        end
        OFS_TRAP1: rdata_q <= t1_q;
        OFS_TRAP2: rdata_q <= t2_q;
        OFS_TRAP3: rdata_q <= t3_q;
        OFS_TRAP4: rdata_q <= t4_q;
        OFS_PEND: rdata_q <= {4'h0, pend_lvl_q, 1'b0, pend_vec_q};
        OFS_FLAG: rdata_q <= flag_q;
        OFS_ENABLE: rdata_q <= enable_q;
        default: begin
          if (reg_addr >= OFS_PRIO0 && reg_addr <= OFS_PRIO3 && !reg_addr[0]) begin
            for (int j = 0; j < SRC_PER_PRIO; j++) begin
              rdata_q[j*PRIO_STRIDE +: PRIO_W] <= prio_q[(32'(reg_addr - OFS_PRIO0) >> 1) * SRC_PER_PRIO + j];
            end
          end
        end
      endcase
    end
  end
  assign reg_rdata = rdata_q;
  assign irq_req = req_q;
  assign irq_vector = pend_vec_q;
  assign irq_level = pend_lvl_q;
  assign trap_req = trap_q;
  assign cpu_level = cur_lvl;
  assign var_latency = var_q;
  // ==========================================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_flag_hold_set: assert property (hw_set[0] |=> flag_q[0])
    else $error("request flag not set by source");
  a_flag_no_self_clear: assert property (flag_q[5] && !(reg_wr && reg_addr == OFS_FLAG) |=> flag_q[5])
    else $error("request flag cleared without a write");
  a_enable_gate_req: assert property (!(|(flag_q & enable_q)) |=> !req_q)
    else $error("request without enabled flag");
  a_gie_blocks_irq: assert property (!global_irq_enable |=> !req_q)
    else $error("request while global enable is clear");
  a_level_blocks_irq: assert property ((lvl_msb_q || lvl_low_q == LVL_LOW_MAX) |=> !req_q)
    else $error("user request above level seven");
  a_pend_above_cpu: assert property (req_q && !$past(level_load) && !$past(irq_ack) &&
    !$past(reg_wr) |-> pend_lvl_q > cur_lvl)
    else $error("pending level not above cpu level");
  a_nest_locks_ipl: assert property (nest_dis && !level_load && !irq_ack |=> $stable(lvl_low_q))
    else $error("low level changed while nesting disabled");
  a_ipl_write_takes: assert property (reg_wr && reg_addr == OFS_STATUS && !nest_dis &&
    !level_load && !irq_ack |=> lvl_low_q == $past(reg_wdata[IPL_MSB:IPL_LSB]))
    else $error("status write did not set low level");
  a_msb_sw_locked: assert property (!level_load |=> $stable(lvl_msb_q))
    else $error("level high bit moved without core");
  a_tie_lower_wins: assert property ((flag_q & enable_q) == 16'h0210 && global_irq_enable && prio_q[4] == prio_q[9] &&
    {1'b0, prio_q[4]} > cur_lvl |=> pend_vec_q == 7'h04)
    else $error("tie not broken toward lower vector");
  a_ovf_trap_gate: assert property (trap_evt[EV_ACC_B_OVF] && !t1_q[T1_B_TE] && !t1_q[T1_ACC_B_OVF] &&
    !reg_wr |=> !t1_q[T1_ACC_B_OVF])
    else $error("overflow flag set while trap disabled");
  a_trap_ignores_gie: assert property (t1_q[T1_DIV0] |=> trap_req)
    else $error("trap request missing");
  a_read_latency: assert property (reg_rd && reg_addr == OFS_FLAG && !reg_wr
    |=> reg_rdata == $past(flag_q))
    else $error("read data wrong one cycle later");
  // ==========================================================================
  // trap, level, write and readback checks
  a_div_flag_sticky: assert property (t1_q[T1_DIV0] && !(reg_wr && reg_addr == OFS_TRAP1)
    |=> t1_q[T1_DIV0])
    else $error("divide flag cleared without a write");
  a_math_with_div: assert property (trap_evt[EV_DIV0] |=> t1_q[T1_DIV0] && t1_q[T1_MATH])
    else $error("divide event did not set math flags");
  a_dma_flag_set: assert property (trap_evt[EV_DMA] |=> t1_q[T1_DMA])
    else $error("dma trap flag not set");
  a_cat_flag_gate: assert property (trap_evt[EV_ACC_B_CAT] && t1_q[T1_CAT_TE] |=> t1_q[T1_ACC_B_CAT])
    else $error("catastrophic flag not set while enabled");
  a_loop_flag_set: assert property (trap_evt[EV_LOOP_OVF] |=> t3_q[T3_LOOP_OVF])
    else $error("loop overflow flag not set");
  a_soft_trap_set: assert property (trap_evt[EV_SOFT_HARD] |=> t4_q[T4_SOFT_HARD])
    else $error("soft hard trap flag not set");
  a_enable_write_takes: assert property (reg_wr && reg_addr == OFS_ENABLE
    |=> enable_q == $past(reg_wdata))
    else $error("enable write did not land");
  a_var_write_takes: assert property (reg_wr && reg_addr == OFS_CORE
    |=> var_latency == $past(reg_wdata[CORE_VAR]))
    else $error("latency select write did not land");
  a_msb_read_back: assert property (reg_rd && reg_addr == OFS_CORE
    |=> reg_rdata[CORE_CPU_PRIORITY_MSB] == $past(cur_lvl > {1'b0, LVL_LOW_MAX}))
    else $error("level high bit read back wrong");
  a_ack_nest_seven: assert property (irq_ack && req_q && nest_dis && !level_load
    |=> lvl_low_q == LVL_LOW_MAX)
    else $error("entry with nesting off not at level seven");
  a_ack_takes_level: assert property (irq_ack && req_q && !nest_dis && !level_load
    |=> lvl_low_q == $past(pend_lvl_q[2:0]))
    else $error("entry did not take pending level");
  c_irq_taken: cover property (req_q ##1 irq_ack);
  c_nested_entry: cover property (irq_ack && req_q && !nest_dis);
  c_trap_seen: cover property (trap_evt[EV_DIV0] ##2 trap_req);
  c_ext_edge: cover property (ext_edge[0] ##1 flag_q[0]);
  c_tie_break: cover property ((flag_q & enable_q) == 16'h0210 ##1 req_q);
endmodule : ipt_ctrl
`default_nettype wire

// file: verification/ipt_core_model.sv
/*
 * processor core partner: acknowledges a presented interrupt after a
 * chosen number of cycles and loads the cpu level on command.
 * assumes the block samples irq_ack and level_load on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module ipt_core_model
  import ipt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic auto_ack,
  input wire logic [3:0] ack_delay,
  input wire logic load_go,
  input wire logic [3:0] load_val,
  input wire logic irq_req,
  output logic irq_ack,
  output logic level_load,
  output logic [3:0] level_value
);
  logic [3:0] wait_q;
  logic done_q;
  // ==========================================================================
  // acknowledge
  // one ack per request: done_q holds off until irq_req falls again
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_ack <= 1'b0;
      wait_q <= 4'h0;
      done_q <= 1'b0;
    end else begin
      irq_ack <= 1'b0;
      if (!irq_req) begin
        done_q <= 1'b0;
        wait_q <= 4'h0;
      end else if (auto_ack && !done_q) begin
        if (wait_q == ack_delay) begin
          irq_ack <= 1'b1;
          done_q <= 1'b1;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
  // ==========================================================================
  // level load
  // value toggles between loads so a stale level is never mistaken for valid
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      level_load <= 1'b0;
      level_value <= 4'h0;
    end else begin
      level_load <= load_go;
      level_value <= load_go ? load_val : ~level_value;
    end
  end
endmodule : ipt_core_model
`default_nettype wire

// file: verification/interrupt_priority_trap_control_bench.sv
/*
 * self-checking bench for ipt_ctrl: reset values, then table of single-source
 * requests, arbitration, level, nesting, pins and trap flags.
 * assumes the register offsets and field positions of ipt_pkg.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module interrupt_priority_trap_control_bench
  import ipt_pkg::*;
;
  typedef struct {int src; logic [2:0] prio;} ipt_row_s;
  logic ref_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [AW-1:0] reg_addr = '0;
  logic [DW-1:0] reg_wdata = '0, reg_rdata;
  logic [NUM_EXT-1:0] ext_pin = '0;
  logic [NUM_SRC-1:0] periph_req = '0;
  logic [NUM_EV-1:0] trap_evt = '0;
  logic irq_ack, level_load, irq_req, trap_req, var_latency;
  logic [3:0] level_value, irq_level, cpu_level;
  logic [6:0] irq_vector;
  logic auto_ack = 1'b0, load_go = 1'b0;
  logic [3:0] ack_delay = 4'h3, load_val = 4'h0;
  int num_errors = 0, tests_run = 0;
  ipt_row_s rows [4] = '{'{0, 3'h1}, '{5, 3'h7}, '{10, 3'h4}, '{15, 3'h3}};
  always #12.5 ref_clk = ~ref_clk;
  ipt_ctrl dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_pin(ext_pin), .periph_req(periph_req),
    .trap_evt(trap_evt), .irq_ack(irq_ack), .level_load(level_load), .level_value(level_value),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_level(irq_level), .trap_req(trap_req),
    .cpu_level(cpu_level), .var_latency(var_latency));
  ipt_core_model core (.ref_clk(ref_clk), .sys_rst(sys_rst), .auto_ack(auto_ack), .ack_delay(ack_delay),
    .load_go(load_go), .load_val(load_val), .irq_req(irq_req), .irq_ack(irq_ack),
    .level_load(level_load), .level_value(level_value));
  // ==========================================================================
  // tasks
  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(nm, exp, reg_rdata)
  endtask : rd_chk
  task automatic pulse(input logic [NUM_SRC-1:0] p, input logic [NUM_EV-1:0] t);
    @(posedge ref_clk);
    periph_req <= p;
    trap_evt <= t;
    @(posedge ref_clk);
    periph_req <= '0;
    trap_evt <= '0;
  endtask : pulse
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle
  task automatic wait_irq(input logic want);
    int n = 0;
    while (irq_req !== want && n < 20) begin
      settle(1);
      n++;
    end
    if (irq_req !== want) begin
      num_errors++;
      $display("Error irq_req wait expected %b seen %b", want, irq_req);
      test_done();
    end
  endtask : wait_irq
  task automatic arm(input int s, input logic [2:0] p);
    wr(OFS_PRIO0 + 8'(2 * (s / SRC_PER_PRIO)), 16'(p) << (PRIO_STRIDE * (s % SRC_PER_PRIO)));
  endtask : arm
  task automatic load(input logic [3:0] v);
    @(posedge ref_clk);
    load_go <= 1'b1;
    load_val <= v;
    @(posedge ref_clk);
    load_go <= 1'b0;
    settle(3);
  endtask : load
  // ==========================================================================
  // sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd_chk("status", OFS_STATUS, 16'h0000);
    rd_chk("core", OFS_CORE, 16'h0000);
    rd_chk("trap1", OFS_TRAP1, 16'h0000);
    rd_chk("trap2", OFS_TRAP2, T2_RESET);
    wr(OFS_PEND, 16'hffff);
    rd_chk("pending", OFS_PEND, 16'h0000);
    wr(8'h1e, 16'hffff);
    rd_chk("unmapped", 8'h1e, 16'h0000);
    foreach (rows[i]) begin
      arm(rows[i].src, rows[i].prio);
      wr(OFS_ENABLE, 16'h1 << rows[i].src);
      pulse(16'h1 << rows[i].src, '0);
      wait_irq(1'b1);
      `CHK("irq_vector", 7'(rows[i].src), irq_vector)
      `CHK("irq_level", {1'b0, rows[i].prio}, irq_level)
      rd_chk("pending", OFS_PEND, (16'(rows[i].prio) << PEND_LVL_LSB) | 16'(rows[i].src));
      rd_chk("flags", OFS_FLAG, 16'h1 << rows[i].src);
      wr(OFS_FLAG, 16'h0000);
      arm(rows[i].src, 3'h0);
      wait_irq(1'b0);
    end
    // equal priority goes to the lower vector, then a raised one overtakes
    arm(4, 3'h5);
    arm(9, 3'h5);
    wr(OFS_ENABLE, 16'h0210);
    pulse(16'h0210, '0);
    wait_irq(1'b1);
    `CHK("irq_vector", 7'h04, irq_vector)
    arm(9, 3'h6);
    settle(3);
    `CHK("irq_vector", 7'h09, irq_vector)
    wr(OFS_TRAP2, 16'h0000);
    settle(3);
    `CHK("irq_req", 1'b0, irq_req)
    pulse('0, NUM_EV'(1) << EV_DIV0);
    settle(2);
    `CHK("trap_req", 1'b1, trap_req)
    rd_chk("trap1", OFS_TRAP1, (16'h1 << T1_DIV0) | (16'h1 << T1_MATH));
    wr(OFS_TRAP1, 16'h0000);
    wr(OFS_TRAP2, T2_RESET);
    wait_irq(1'b1);
    wr(OFS_STATUS, 16'h00a0);
    settle(3);
    `CHK("cpu_level", 4'h5, cpu_level)
    `CHK("irq_req", 1'b1, irq_req)
    wr(OFS_STATUS, 16'h00e0);
    wait_irq(1'b0);
    wr(OFS_CORE, 16'h0008);
    rd_chk("core", OFS_CORE, 16'h0000);
    load(4'h9);
    `CHK("cpu_level", 4'h9, cpu_level)
    rd_chk("core", OFS_CORE, 16'h0008);
    rd_chk("status", OFS_STATUS, 16'h0020);
    wr(OFS_STATUS, 16'h0000);
    settle(3);
    `CHK("cpu_level", 4'h8, cpu_level)
    `CHK("irq_req", 1'b0, irq_req)
    load(4'h0);
    wait_irq(1'b1);
    wr(OFS_TRAP1, 16'h8000);
    wr(OFS_STATUS, 16'h0060);
    rd_chk("status", OFS_STATUS, 16'h0000);
    rd_chk("trap1", OFS_TRAP1, 16'h8000);
    auto_ack <= 1'b1;
    wait_irq(1'b0);
    `CHK("cpu_level", 4'h7, cpu_level)
    wr(OFS_TRAP1, 16'h0000);
    ack_delay <= 4'h0;
    wr(OFS_STATUS, 16'h0000);
    wait_irq(1'b1);
    wait_irq(1'b0);
    `CHK("cpu_level", 4'h6, cpu_level)
    auto_ack <= 1'b0;
    rd_chk("flags", OFS_FLAG, 16'h0210);
    wr(OFS_FLAG, 16'h0000);
    wr(OFS_STATUS, 16'h0000);
    // pin 0 set for falling edge, pin 1 left on rising edge
    wr(OFS_TRAP2, 16'h8001);
    wr(OFS_PRIO0, 16'h0022);
    wr(OFS_ENABLE, 16'h0003);
    ext_pin <= 3'b001;
    settle(8);
    `CHK("irq_req", 1'b0, irq_req)
    ext_pin <= 3'b000;
    wait_irq(1'b1);
    `CHK("irq_vector", 7'h00, irq_vector)
    wr(OFS_FLAG, 16'h0000);
    wait_irq(1'b0);
    ext_pin <= 3'b010;
    wait_irq(1'b1);
    `CHK("irq_vector", 7'h01, irq_vector)
    wr(OFS_FLAG, 16'h0000);
    wr(OFS_ENABLE, 16'h0000);
    wr(OFS_TRAP1, 16'h0700);
    rd_chk("trap1", OFS_TRAP1, 16'h0700);
    pulse('0, (NUM_EV'(1) << EV_ACC_A_OVF) | (NUM_EV'(1) << EV_ACC_B_CAT) | (NUM_EV'(1) << EV_DMA)
      | (NUM_EV'(1) << EV_LOOP_OVF) | (NUM_EV'(1) << EV_SOFT_HARD));
    rd_chk("trap1", OFS_TRAP1, 16'h4f20);
    rd_chk("trap3", OFS_TRAP3, 16'h0010);
    rd_chk("trap4", OFS_TRAP4, 16'h0001);
    `CHK("trap_req", 1'b1, trap_req)
    wr(OFS_TRAP1, 16'h0000);
    wr(OFS_TRAP3, 16'h0000);
    wr(OFS_TRAP4, 16'h0000);
    pulse('0, NUM_EV'(1) << EV_ACC_B_OVF);
    rd_chk("trap1", OFS_TRAP1, 16'h0000);
    `CHK("trap_req", 1'b0, trap_req)
    wr(OFS_CORE, 16'h8000);
    settle(2);
    `CHK("var_latency", 1'b1, var_latency)
    rd_chk("core", OFS_CORE, 16'h8000);
    test_done();
  end
endmodule : interrupt_priority_trap_control_bench
`default_nettype wire
